//--- verilog/vic_pkg.sv
// Purpose: Shared constants and types for the vectored event controller
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: Vector addresses are 16-bit word addresses into page zero, except software and boot vectors
`default_nettype none
package vic_pkg;
  localparam int NUM_EVT = 9;
  localparam int NUM_SWI = 7;
  localparam int NUM_TRAP = 16;
  localparam int NUM_HWT = 5;
  localparam int PRIO_W = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_ENABLE_LOW = 8'h00;
  localparam logic [7:0] OFS_ENABLE_HIGH = 8'h04;
  localparam logic [7:0] OFS_PRIO_0 = 8'h08;
  localparam logic [7:0] OFS_SWI_REQ = 8'h20;
  localparam logic [7:0] OFS_SWI_EN = 8'h24;
  localparam logic [7:0] OFS_CTRL = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
  localparam logic [7:0] OFS_BOOT_VEC = 8'h38;
  localparam int NUM_PRIO_REG = 6;
  // Field positions
  localparam int BIT_GLOBAL_EN = 7;
  localparam int FLD_LO_LSB = 0;
  localparam int FLD_HI_LSB = 4;
  localparam int CTRL_FORCE_BOOT = 0;
  localparam int CTRL_EXT0_LEVEL = 1;
  localparam int CTRL_EXT1_LEVEL = 2;
  // Fixed vectors
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_HWT_BASE = 16'h0004;
  localparam logic [15:0] VEC_TRAP_BASE = 16'h0040;
  localparam logic [15:0] VEC_SWI_BASE = 16'h0100;
  localparam logic [1:0] RSP_OKAY = 2'h0;
  localparam logic [1:0] RSP_SLVERR = 2'h2;
  localparam logic [3:0] PRIO_TRAP = 4'hF;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
  // Interrupt status bits
  localparam int IRQ_ENTRY = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_RESET = 2;

  typedef enum logic [1:0] {
    VIC_KIND_RESET = 2'h0,
    VIC_KIND_TRAP = 2'h1,
    VIC_KIND_EVENT = 2'h2,
    VIC_KIND_SWI = 2'h3
  } vic_kind_t;

  typedef struct packed {
    logic valid;
    vic_kind_t kind;
    logic [5:0] source;
    logic [3:0] prio;
    logic [15:0] vector;
  } vic_req_t;
endpackage : vic_pkg
`default_nettype wire

//--- verilog/vic_top.sv
// Purpose: Vectored event, trap and reset controller with AXI4-Lite registers
// Assumes: One 10 MHz clock, synchronous active-high reset, core acks entries
// Notes: One request presented at a time and held until acknowledged
//
// Summary of operation
// - Thirty-eight vectored sources: events, exceptions, traps, software requests.
// - Each event has seven priority levels; global and per-source enables.
// - Event accepted only when global enable and own enable both set.
// - Three-bit priority field: zero disables, n maps to n plus eight.
// - Six priority registers, fields in bits 2-0 and 6-4.
// - Equal priority resolved by rank: reset, traps, then events 2..10.
// - Resets vector through word at address 0000 unless the boot vector is selected.
// - Hardware traps at fixed vectors 0004 to 0014, rank one.
// - Sixteen trap instructions vector within 0040 to 007F.
// - Event vectors at 0080 through 00AC as listed.
// - Every vector is sixteen bits, page zero except software and boot vectors.
// - Reset release raises reset exception, vectored through location 0000.
// - Boot vector replaces reset address when forced or flash status nonzero.
// - Power-down wake only by enabled level-sensitive external request.
// - Data memory is not cleared by reset.
// - Software interrupts act like events, raised only by register writes.
`default_nettype none
module vic_top #(
  parameter logic [15:0] BOOT_VEC_DEF = 16'h0000 // Arbitrary default
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [vic_pkg::NUM_EVT-1:0] event_flags_in,
  input wire logic [vic_pkg::NUM_HWT-1:0] hw_trap_in,
  input wire logic trap_req_in,
  input wire logic [3:0] trap_num_in,
  input wire logic flash_status_nonzero_in,
  input wire logic power_down_in,
  input wire logic [3:0] core_prio_in,
  input wire logic core_ack_in,
  output logic req_valid_out,
  output logic [15:0] req_vector_out,
  output logic [3:0] req_prio_out,
  output logic [1:0] req_kind_out,
  output logic wake_out,
  output logic irq_out
);
  localparam int NE = vic_pkg::NUM_EVT;
  localparam int NS = vic_pkg::NUM_SWI;

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] en_low_r, en_low_nxt, en_high_r, en_high_nxt;
  logic [7:0] prio_r [vic_pkg::NUM_PRIO_REG];
  logic [7:0] prio_nxt [vic_pkg::NUM_PRIO_REG];
  logic [NS-1:0] swi_req_r, swi_req_nxt, swi_en_r, swi_en_nxt;
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [2:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
  logic [15:0] boot_vec_r, boot_vec_nxt;
  logic awdone_r, awdone_nxt, wdone_r, wdone_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  vic_pkg::vic_req_t cur_r, cur_nxt, best;
  logic rst_pend_r, rst_pend_nxt, wake_r, wake_nxt, irq_r, irq_nxt;

  // Event enable bit positions: ext0,tmr0,ext1,tmr1,tmr2 low; serial high
  function automatic logic evt_enable(input int i, input logic [7:0] lo,
                                      input logic [7:0] hi);
    evt_enable = (i < 5) ? lo[i] : hi[i-5];
  endfunction

  // Event index to priority register and field
  function automatic logic [2:0] evt_field(input int i, input logic [7:0] p0,
      input logic [7:0] p1, input logic [7:0] p2, input logic [7:0] p4,
      input logic [7:0] p5);
    unique case (i)
      0: evt_field = p0[2:0];
      1: evt_field = p0[6:4];
      2: evt_field = p1[2:0];
      3: evt_field = p1[6:4];
      4: evt_field = p2[2:0];
      5: evt_field = p4[2:0];
      6: evt_field = p4[6:4];
      7: evt_field = p5[2:0];
      default: evt_field = p5[6:4];
    endcase
  endfunction

  function automatic logic [15:0] evt_vector(input int i);
    unique case (i)
      0: evt_vector = 16'h0080;
      1: evt_vector = 16'h0084;
      2: evt_vector = 16'h0088;
      3: evt_vector = 16'h008C;
      4: evt_vector = 16'h0090;
      5: evt_vector = 16'h00A0;
      6: evt_vector = 16'h00A4;
      7: evt_vector = 16'h00A8;
      default: evt_vector = 16'h00AC;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Effective priorities and arbitration
  logic [3:0] evt_prio [NE];
  logic [NE-1:0] evt_live;
  genvar g;
  generate
    for (g = 0; g < NE; g++) begin : g_evt
      logic [2:0] fld;
      assign fld = evt_field(g, prio_r[0], prio_r[1], prio_r[2], prio_r[4], prio_r[5]);
      assign evt_prio[g] = (fld == 3'h0) ? 4'h0 : {1'b1, fld};
      assign evt_live[g] = event_flags_in[g] && en_low_r[vic_pkg::BIT_GLOBAL_EN]
                           && evt_enable(g, en_low_r, en_high_r)
                           && (evt_prio[g] > core_prio_in);
    end
  endgenerate

  always_comb begin
    best = '0;
    // Scan from highest rank number downward so lower rank numbers overwrite on ties
    for (int i = NS - 1; i >= 0; i--) begin
      if (swi_req_r[i] && swi_en_r[i] && (4'(i + 1) > core_prio_in)
          && (!best.valid || 4'(i + 1) >= best.prio)) begin
        best.valid = 1'b1;
        best.kind = vic_pkg::VIC_KIND_SWI;
        best.source = 6'(i);
        best.prio = 4'(i + 1);
        best.vector = vic_pkg::VEC_SWI_BASE + 16'(4 * i);
      end
    end
    for (int i = NE - 1; i >= 0; i--) begin
      if (evt_live[i] && (!best.valid || evt_prio[i] >= best.prio)) begin
        best.valid = 1'b1;
        best.kind = vic_pkg::VIC_KIND_EVENT;
        best.source = 6'(i);
        best.prio = evt_prio[i];
        best.vector = evt_vector(i);
      end
    end
    if (trap_req_in) begin
      best.valid = 1'b1;
      best.kind = vic_pkg::VIC_KIND_TRAP;
      best.source = 6'(vic_pkg::NUM_HWT) + {2'h0, trap_num_in};
      best.prio = vic_pkg::PRIO_TRAP;
      best.vector = vic_pkg::VEC_TRAP_BASE + {10'h000, trap_num_in, 2'h0};
    end
    for (int i = vic_pkg::NUM_HWT - 1; i >= 0; i--) begin
      if (hw_trap_in[i]) begin
        best.valid = 1'b1;
        best.kind = vic_pkg::VIC_KIND_TRAP;
        best.source = 6'(i);
        best.prio = vic_pkg::PRIO_TRAP;
        best.vector = vic_pkg::VEC_HWT_BASE + 16'(4 * i);
      end
    end
    if (rst_pend_r) begin
      best.valid = 1'b1;
      best.kind = vic_pkg::VIC_KIND_RESET;
      best.source = 6'h00;
      best.prio = vic_pkg::PRIO_TRAP;
      best.vector = (ctrl_r[vic_pkg::CTRL_FORCE_BOOT] || flash_status_nonzero_in)
                    ? boot_vec_r : vic_pkg::VEC_RESET;
    end
  end

  // Presented request held until ack, then next winner
  always_comb begin
    cur_nxt = cur_r;
    rst_pend_nxt = rst_pend_r;
    if (!cur_r.valid || core_ack_in) begin
      cur_nxt = core_ack_in ? '0 : best;
      if (core_ack_in && cur_r.valid && cur_r.kind == vic_pkg::VIC_KIND_RESET) begin
        rst_pend_nxt = 1'b0;
      end
    end
    // Level-sensitive enabled external request wakes power-down
    wake_nxt = power_down_in && en_low_r[vic_pkg::BIT_GLOBAL_EN] &&
      ((event_flags_in[0] && en_low_r[0] && ctrl_r[vic_pkg::CTRL_EXT0_LEVEL]) ||
       (event_flags_in[2] && en_low_r[2] && ctrl_r[vic_pkg::CTRL_EXT1_LEVEL]));
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic wr_go, rd_go;
  logic [NS-1:0] swi_wr_val;
  always_comb begin
    awdone_nxt = awdone_r;
    wdone_nxt = wdone_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    if (s_axi_awvalid_in && !awdone_r) begin
      awdone_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr_in[7:0];
    end
    if (s_axi_wvalid_in && !wdone_r) begin
      wdone_nxt = 1'b1;
      wdata_nxt = s_axi_wdata_in;
    end
    wr_go = awdone_r && wdone_r && !bvalid_r;
    if (wr_go) begin
      awdone_nxt = 1'b0;
      wdone_nxt = 1'b0;
    end
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (bvalid_r && s_axi_bready_in) bvalid_nxt = 1'b0;
    en_low_nxt = en_low_r;
    en_high_nxt = en_high_r;
    prio_nxt = prio_r;
    swi_req_nxt = swi_req_r;
    swi_en_nxt = swi_en_r;
    ctrl_nxt = ctrl_r;
    irq_mask_nxt = irq_mask_r;
    boot_vec_nxt = boot_vec_r;
    irq_stat_nxt = irq_stat_r;
    swi_wr_val = wdata_r[NS-1:0];
    // Entry clears a taken software request; a new write of it still wins
    if (core_ack_in && cur_r.valid && cur_r.kind == vic_pkg::VIC_KIND_SWI) begin
      swi_req_nxt[cur_r.source[2:0]] = 1'b0;
    end
    if (wr_go) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = vic_pkg::RSP_OKAY;
      unique case (awaddr_r & 8'hFC)
        vic_pkg::OFS_ENABLE_LOW: en_low_nxt = wdata_r[7:0];
        vic_pkg::OFS_ENABLE_HIGH: en_high_nxt = {4'h0, wdata_r[3:0]};
        vic_pkg::OFS_SWI_REQ: swi_req_nxt = swi_wr_val;
        vic_pkg::OFS_SWI_EN: swi_en_nxt = swi_wr_val;
        vic_pkg::OFS_CTRL: ctrl_nxt = wdata_r[2:0];
        vic_pkg::OFS_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~wdata_r[2:0];
        vic_pkg::OFS_IRQ_MASK: irq_mask_nxt = wdata_r[2:0];
        vic_pkg::OFS_BOOT_VEC: boot_vec_nxt = wdata_r[15:0];
        default: begin
          if (awaddr_r >= vic_pkg::OFS_PRIO_0 && awaddr_r < vic_pkg::OFS_SWI_REQ) begin
            prio_nxt[3'((awaddr_r - vic_pkg::OFS_PRIO_0) >> 2)] = wdata_r[7:0] & 8'h77;
          end else begin
            bresp_nxt = vic_pkg::RSP_SLVERR;
          end
        end
      endcase
    end
    // Status events set after any clear so the set wins
    if (core_ack_in && cur_r.valid) irq_stat_nxt[vic_pkg::IRQ_ENTRY] = 1'b1;
    if (wake_r) irq_stat_nxt[vic_pkg::IRQ_WAKE] = 1'b1;
    if (rst_pend_r) irq_stat_nxt[vic_pkg::IRQ_RESET] = 1'b1;
    irq_nxt = |(irq_stat_r & irq_mask_r);
    rd_go = s_axi_arvalid_in && !rvalid_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && s_axi_rready_in) rvalid_nxt = 1'b0;
    if (rd_go) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = vic_pkg::RSP_OKAY;
      unique case (s_axi_araddr_in[7:0] & 8'hFC)
        vic_pkg::OFS_ENABLE_LOW: rdata_nxt = {24'h0, en_low_r};
        vic_pkg::OFS_ENABLE_HIGH: rdata_nxt = {24'h0, en_high_r};
        vic_pkg::OFS_SWI_REQ: rdata_nxt = {25'h0, swi_req_r};
        vic_pkg::OFS_SWI_EN: rdata_nxt = {25'h0, swi_en_r};
        vic_pkg::OFS_CTRL: rdata_nxt = {29'h0, ctrl_r};
        vic_pkg::OFS_STATUS: rdata_nxt = {cur_r.vector, 3'h0, cur_r.valid,
                                          cur_r.prio, 6'h0, cur_r.kind};
        vic_pkg::OFS_IRQ_STAT: rdata_nxt = {29'h0, irq_stat_r};
        vic_pkg::OFS_IRQ_MASK: rdata_nxt = {29'h0, irq_mask_r};
        vic_pkg::OFS_BOOT_VEC: rdata_nxt = {16'h0, boot_vec_r};
        default: begin
          if (s_axi_araddr_in[7:0] >= vic_pkg::OFS_PRIO_0
              && s_axi_araddr_in[7:0] < vic_pkg::OFS_SWI_REQ) begin
            rdata_nxt = {24'h0, prio_r[3'((s_axi_araddr_in[7:0] - vic_pkg::OFS_PRIO_0) >> 2)]};
          end else begin
            rdata_nxt = vic_pkg::RST_VAL;
            rresp_nxt = vic_pkg::RSP_SLVERR;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers; no data memory is touched by reset here
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      en_low_r <= 8'h00;
      en_high_r <= 8'h00;
      for (int i = 0; i < vic_pkg::NUM_PRIO_REG; i++) prio_r[i] <= 8'h00;
      swi_req_r <= '0;
      swi_en_r <= '0;
      ctrl_r <= 3'h0;
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
      boot_vec_r <= BOOT_VEC_DEF;
      awdone_r <= 1'b0;
      wdone_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h0000_0000;
      cur_r <= '0;
      rst_pend_r <= 1'b1;
      wake_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      en_low_r <= en_low_nxt;
      en_high_r <= en_high_nxt;
      prio_r <= prio_nxt;
      swi_req_r <= swi_req_nxt;
      swi_en_r <= swi_en_nxt;
      ctrl_r <= ctrl_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      boot_vec_r <= boot_vec_nxt;
      awdone_r <= awdone_nxt;
      wdone_r <= wdone_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      cur_r <= cur_nxt;
      rst_pend_r <= rst_pend_nxt;
      wake_r <= wake_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign s_axi_awready_out = !awdone_r;
  assign s_axi_wready_out = !wdone_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = !rvalid_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;
  assign req_valid_out = cur_r.valid;
  assign req_vector_out = cur_r.vector;
  assign req_prio_out = cur_r.prio;
  assign req_kind_out = cur_r.kind;
  assign wake_out = wake_r;
  assign irq_out = irq_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_req_held: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    cur_r.valid && !core_ack_in |=> $stable(cur_r))
    else $error("Request changed before ack");
  a_reset_first: assert property (@(posedge core_clk_in)
    $fell(sys_rst_in) |=> cur_r.valid && cur_r.kind == vic_pkg::VIC_KIND_RESET)
    else $error("Reset exception not presented first");
  a_reset_vec: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    cur_r.valid && cur_r.kind == vic_pkg::VIC_KIND_RESET && !ctrl_r[0]
    && !flash_status_nonzero_in |-> cur_r.vector == 16'h0000)
    else $error("Reset vector not zero");
  a_evt_gate: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !en_low_r[7] && !cur_r.valid && !rst_pend_r && hw_trap_in == '0 && !trap_req_in
    && swi_req_r == '0 |=> !cur_r.valid)
    else $error("Event taken with global enable clear");
  a_evt_prio: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    cur_r.valid && cur_r.kind == vic_pkg::VIC_KIND_EVENT |-> cur_r.prio[3]
    && cur_r.vector[15:8] == 8'h00 && cur_r.vector[7])
    else $error("Bad event priority or vector");
  a_trap_vec: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    cur_r.valid && cur_r.kind == vic_pkg::VIC_KIND_TRAP |-> cur_r.vector < 16'h0080
    && cur_r.vector[1:0] == 2'h0)
    else $error("Trap vector out of range");
  a_wake_cond: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    wake_out |-> $past(power_down_in) && $past(en_low_r[7]))
    else $error("Wake without enabled level request");
  a_above_core: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !cur_r.valid ##1 cur_r.valid && cur_r.kind == vic_pkg::VIC_KIND_EVENT
    |-> cur_r.prio > $past(core_prio_in))
    else $error("Event not above core priority");
  c_reset_entry: cover property (@(posedge core_clk_in)
    cur_r.kind == vic_pkg::VIC_KIND_RESET && core_ack_in);
  c_event_entry: cover property (@(posedge core_clk_in)
    cur_r.kind == vic_pkg::VIC_KIND_EVENT && core_ack_in);
  c_swi_entry: cover property (@(posedge core_clk_in)
    cur_r.kind == vic_pkg::VIC_KIND_SWI && core_ack_in);
  c_wake: cover property (@(posedge core_clk_in) wake_out);
endmodule // vic_top
`default_nettype wire

//--- tb/vic_core_model.sv
// Purpose: Behavioural processor core that takes presented entries
// Assumes: One clock, synchronous active-high reset
// Notes: Ack delay set by the bench; fields captured at the ack
`default_nettype none
module vic_core_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire logic [15:0] req_vector_in,
  input wire logic [3:0] req_prio_in,
  input wire logic [1:0] req_kind_in,
  input wire logic [3:0] ack_delay_in,
  output logic core_ack_out,
  output logic [15:0] taken_vec_out,
  output logic [3:0] taken_prio_out,
  output logic [1:0] taken_kind_out,
  output logic [7:0] taken_cnt_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_r;
  ////////////////////////////////////////////////////////////////
  // Delay of 2 or more keeps a dropping request from a second ack
  always_ff @(posedge clk_in) begin
    core_ack_out <= 1'b0;
    if (rst_in) begin
      taken_cnt_out <= 8'h00;
    end
    if (rst_in || !req_valid_in || core_ack_out) begin
      wait_r <= 4'h0;
    end else if (wait_r + 4'h1 >= ack_delay_in) begin
      core_ack_out <= 1'b1;
      taken_vec_out <= req_vector_in;
      taken_prio_out <= req_prio_in;
      taken_kind_out <= req_kind_in;
      taken_cnt_out <= taken_cnt_out + 8'h01;
      wait_r <= 4'h0;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule // vic_core_model
`default_nettype wire

//--- tb/tb_vectored_interrupt_controller.sv
// Purpose: Self-checking bench for the vectored event controller
// Assumes: AXI4-Lite register access, core modelled separately
// Notes: Boot vector default overridden so its use is visible
`default_nettype none
module tb_vectored_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, trap_req, flash_nz, pdown, ack;
  logic awready, wready, bvalid, arready, rvalid, req_valid, wake, irq;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [1:0] bresp, rresp, req_kind, tkind, rs, bs;
  logic [8:0] ev;
  logic [4:0] hwt;
  logic [3:0] trap_num, core_prio, req_prio, tprio, ack_dly, pv;
  logic [15:0] req_vec, tvec;
  logic [7:0] tcnt;
  int n_errors, checks_done;
  localparam logic [15:0] EVEC [9] = '{16'h0080, 16'h0084, 16'h0088, 16'h008C, 16'h0090,
                                       16'h00A0, 16'h00A4, 16'h00A8, 16'h00AC};
  localparam int PREG [9] = '{0, 0, 1, 1, 2, 4, 4, 5, 5};
  localparam logic [8:0] HI_FLD = 9'h14A;

  vic_top #(.BOOT_VEC_DEF(16'h0ABC)) dut (.core_clk_in(clk), .sys_rst_in(rst),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .event_flags_in(ev),
    .hw_trap_in(hwt), .trap_req_in(trap_req), .trap_num_in(trap_num),
    .flash_status_nonzero_in(flash_nz), .power_down_in(pdown), .core_prio_in(core_prio),
    .core_ack_in(ack), .req_valid_out(req_valid), .req_vector_out(req_vec),
    .req_prio_out(req_prio), .req_kind_out(req_kind), .wake_out(wake), .irq_out(irq));

  vic_core_model core (.clk_in(clk), .rst_in(rst), .req_valid_in(req_valid),
    .req_vector_in(req_vec), .req_prio_in(req_prio), .req_kind_in(req_kind),
    .ack_delay_in(ack_dly), .core_ack_out(ack), .taken_vec_out(tvec),
    .taken_prio_out(tprio), .taken_kind_out(tkind), .taken_cnt_out(tcnt));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done, aw_go, w_go;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge clk);
      aw_go = awready && !aw_done;
      w_go = wready && !w_done;
      @(posedge clk);
      if (aw_go) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (w_go) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(negedge clk); while (!bvalid);
    bs = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    rd = rdata;
    rs = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask

  // Sources drop at the edge where the core's ack is sampled
  task automatic expect_entry(input logic [15:0] v, input logic [3:0] p,
                              input logic [1:0] k, input logic [8:0] keep);
    logic [7:0] c0;
    c0 = tcnt;
    do @(negedge clk); while (tcnt === c0);
    @(posedge clk);
    ev <= ev & keep;
    hwt <= 5'h00;
    trap_req <= 1'b0;
    chk("vector", {16'h0, v}, {16'h0, tvec});
    chk("prio", {28'h0, p}, {28'h0, tprio});
    chk("kind", {30'h0, k}, {30'h0, tkind});
    repeat (3) @(posedge clk);
  endtask

  task automatic expect_none();
    repeat (20) begin
      @(negedge clk);
      chk("idle", 32'h0, {31'h0, req_valid});
    end
    @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, trap_req, flash_nz, pdown} = '0;
    {awaddr, wdata, araddr, ev, hwt, trap_num, core_prio} = '0;
    rst = 1'b1;
    ack_dly = 4'h3;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    expect_entry(16'h0000, 4'hF, 2'h0, 9'h0);
    axr(vic_pkg::OFS_ENABLE_LOW);
    chk("enable_low", vic_pkg::RST_VAL, rd);
    axr(8'h3C);
    chk("unmapped", {30'h0, vic_pkg::RSP_SLVERR}, {30'h0, rs});
    axw(vic_pkg::OFS_STATUS, 32'h0);
    chk("wr_resp", {30'h0, vic_pkg::RSP_SLVERR}, {30'h0, bs});
    $display("test reset done");
    axw(vic_pkg::OFS_ENABLE_LOW, 32'h9F);
    axw(vic_pkg::OFS_ENABLE_HIGH, 32'hF);
    for (int i = 0; i < 9; i++) begin
      pv = 4'(i % 7 + 1);
      axw(8'(vic_pkg::OFS_PRIO_0 + 4 * PREG[i]), {28'h0, pv} << (HI_FLD[i] ? 4 : 0));
      ack_dly <= i[0] ? 4'h9 : 4'h3;
      ev <= 9'h1 << i;
      expect_entry(EVEC[i], 4'h8 + pv, 2'h2, 9'h0);
    end
    $display("test events done");
    axw(vic_pkg::OFS_PRIO_0, 32'h0);
    ev <= 9'h1;
    expect_none();
    axw(vic_pkg::OFS_ENABLE_LOW, 32'h1F);
    axw(vic_pkg::OFS_PRIO_0, 32'h11);
    expect_none();
    core_prio <= 4'h9;
    axw(vic_pkg::OFS_ENABLE_LOW, 32'h9F);
    expect_none();
    core_prio <= 4'h8;
    ev <= 9'h3;
    expect_entry(16'h0080, 4'h9, 2'h2, 9'h2);
    expect_entry(16'h0084, 4'h9, 2'h2, 9'h0);
    $display("test gating done");
    for (int i = 0; i < 21; i++) begin
      if (i < 5) begin
        hwt <= 5'h1 << i;
      end else begin
        trap_req <= 1'b1;
        trap_num <= 4'(i - 5);
      end
      expect_entry(i < 5 ? 16'h0004 + 16'(4 * i) : 16'h0040 + 16'(4 * (i - 5)),
                   4'hF, 2'h1, 9'h0);
    end
    $display("test traps done");
    core_prio <= 4'hF;
    pdown <= 1'b1;
    axw(vic_pkg::OFS_CTRL, 32'h2);
    ev <= 9'h1;
    repeat (4) @(negedge clk);
    chk("wake", 32'h1, {31'h0, wake});
    axw(vic_pkg::OFS_CTRL, 32'h0);
    repeat (4) @(negedge clk);
    chk("wake", 32'h0, {31'h0, wake});
    @(posedge clk);
    ev <= 9'h0;
    pdown <= 1'b0;
    $display("test wake done");
    chk("irq", 32'h0, {31'h0, irq});
    axw(vic_pkg::OFS_IRQ_MASK, 32'h1);
    axr(vic_pkg::OFS_IRQ_STAT);
    chk("irq_stat", 32'h1, rd & 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    axw(vic_pkg::OFS_IRQ_STAT, 32'h7);
    repeat (2) @(negedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test irq done");
    @(posedge clk);
    core_prio <= 4'h0;
    axw(vic_pkg::OFS_SWI_EN, 32'h7F);
    axw(vic_pkg::OFS_SWI_REQ, 32'h6);
    expect_entry(16'h0108, 4'h3, 2'h3, 9'h0);
    expect_entry(16'h0104, 4'h2, 2'h3, 9'h0);
    axr(vic_pkg::OFS_SWI_REQ);
    chk("swi_req", 32'h0, rd);
    $display("test swi done");
    @(posedge clk);
    core_prio <= 4'h0;
    flash_nz <= 1'b1;
    rst <= 1'b1;
    repeat (100) @(posedge clk);
    rst <= 1'b0;
    expect_entry(16'h0ABC, 4'hF, 2'h0, 9'h0);
    $display("test boot done");
    print_verdict();
  end
endmodule // tb_vectored_interrupt_controller
`default_nettype wire
